//--- emr_pkg.sv
// Constants and types for the extended mode register block.
package emr_pkg;
    // Bank address selections of a mode register set command.
    localparam logic [1:0] EMR_SEL_MAIN = 2'h0;
    localparam logic [1:0] EMR_SEL_ONE  = 2'h1;
    localparam logic [1:0] EMR_SEL_TWO  = 2'h2;
    // Field positions in the first extended register, and the widths of both registers.
    localparam int EMR_DLL_BIT    = 0;
    localparam int EMR_DRV_BIT    = 1;
    localparam int EMR_TERM_LO    = 2;
    localparam int EMR_LAT_LO     = 3;
    localparam int EMR_TERM_HI    = 6;
    localparam int EMR_CAL_LO     = 7;
    localparam int EMR_STROBE_BIT = 10;
    localparam int EMR_QOFF_BIT   = 12;
    localparam int EMR_ONE_W      = 13;
    localparam int EMR_TWO_W      = 16;
    // Reset values chosen for the model; the real part has none defined.
    localparam logic [12:0] EMR_ONE_RST = 13'h0000;
    localparam logic [15:0] EMR_TWO_RST = 16'h0000;
    // Largest legal added latency.
    localparam logic [2:0] EMR_LAT_MAX = 3'h5;
    // Driver calibration codes.
    localparam logic [2:0] EMR_CAL_EXIT = 3'h0;
    localparam logic [2:0] EMR_CAL_HIGH = 3'h1;
    localparam logic [2:0] EMR_CAL_LOW  = 3'h2;
    localparam logic [2:0] EMR_CAL_ADJ  = 3'h4;
    localparam logic [2:0] EMR_CAL_DEF  = 3'h7;
    // Termination encodings, nominal ohms.
    localparam logic [1:0] EMR_TERM_OFF = 2'h0;
    localparam logic [1:0] EMR_TERM_75  = 2'h1;
    localparam logic [1:0] EMR_TERM_150 = 2'h2;
    localparam logic [1:0] EMR_TERM_50  = 2'h3;
    // Clocks the loop needs to lock after it is enabled.
    localparam int EMR_LOCK_CYC = 200;
    localparam logic [7:0] EMR_LOCK_CNT = 8'(EMR_LOCK_CYC);
    typedef enum logic [2:0] {
        CAL_EXIT, CAL_HIGH, CAL_LOW, CAL_ADJUST, CAL_DEFAULT, CAL_BAD
    } emr_cal_t;
endpackage

//--- emr_cmd_decode.sv
// Decoder that recognises mode register set commands to each extended register.
`timescale 1ns/1ps
`default_nettype none
module emr_cmd_decode
    import emr_pkg::*;
(
    // Command pins, sampled.
    input  wire logic       csN,
    input  wire logic       rasN,
    input  wire logic       casN,
    input  wire logic       weN,
    input  wire logic [1:0] bankAddr,
    // Decoded strobes.
    output logic            loadOne,
    output logic            loadTwo
);
    logic isModeSet;
    always_comb begin
        isModeSet = !csN && !rasN && !casN && !weN;
        loadOne   = isModeSet && (bankAddr == EMR_SEL_ONE); // [RULE_01]
        loadTwo   = isModeSet && (bankAddr == EMR_SEL_TWO); // [RULE_02]
    end
endmodule
`default_nettype wire

//--- emr_extended_mode.sv
// Extended mode registers of a four-bank DDR2 memory and their decoded controls.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - Command with bank one loads first register
// RULE_02 - Command with bank two loads second register
// RULE_03 - Controller programs both registers after power-up
// RULE_04 - Controller precharges banks, clock enable high
// RULE_05 - Controller waits mode set cycle time
// RULE_06 - Rewrites allowed while all banks precharged
// RULE_07 - Bit zero low enables the loop
// RULE_08 - Bit one selects weak output driver
// RULE_09 - Bits six and two select termination
// RULE_10 - Bits five to three give added latency
// RULE_11 - Bits nine to seven set calibration mode
// RULE_12 - Controller exits calibration after default load
// RULE_13 - Bit ten disables complementary strobe
// RULE_14 - Bit twelve turns output buffers off
// RULE_15 - Controller keeps loop enabled for operation
// RULE_16 - Self refresh disables loop, exit restores it
// RULE_17 - Controller waits 200 clocks before reads
// RULE_18 - Adjust mode keeps earlier added latency
// RULE_19 - Controller drives bit eleven low
// RULE_20 - Fields change only on selecting command
module emr_extended_mode
    import emr_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Command and address pins.
    input  wire logic        csN,
    input  wire logic        rasN,
    input  wire logic        casN,
    input  wire logic        weN,
    input  wire logic [1:0]  bankAddr,
    input  wire logic [15:0] addr,
    input  wire logic        selfRefresh,
    // First register fields, lock status and both register values.
    output logic             dllOn,
    output logic             weakDrive,
    output logic [1:0]       termSel,
    output logic [2:0]       addedLatency,
    output var emr_cal_t     driverCalibration,
    output logic             strobeCompOff,
    output logic             outputsOff,
    output logic             dllLocked,
    output logic [12:0]      emrOneValue,
    output logic [15:0]      emrTwoValue
);
    // Pins are two-flopped; the command word as a whole is delayed by two cycles.
    logic [3:0]  cmdS1_q, cmdS2_q;
    logic [1:0]  bankS1_q, bankS2_q;
    logic [15:0] addrS1_q, addrS2_q;
    logic        srS1_q, srS2_q;
    logic        loadOne, loadTwo;
    logic [12:0] one_q, one_d;
    logic [15:0] two_q, two_d;
    logic        dllOn_q, dllOn_d;
    logic [7:0]  lockCnt_q, lockCnt_d;
    logic        locked_q, locked_d;
    logic        weak_q, weak_d;
    logic [1:0]  term_q, term_d;
    logic [2:0]  lat_q, lat_d;
    emr_cal_t    cal_q, cal_d;
    logic        comp_q, comp_d;
    logic        qoff_q, qoff_d;
    logic [8:0]  onCycles_q, onCycles_d;

    function automatic emr_cal_t decodeCal(input logic [2:0] code);
        case (code)
            EMR_CAL_EXIT: decodeCal = CAL_EXIT;
            EMR_CAL_HIGH: decodeCal = CAL_HIGH;
            EMR_CAL_LOW:  decodeCal = CAL_LOW;
            EMR_CAL_ADJ:  decodeCal = CAL_ADJUST;
            EMR_CAL_DEF:  decodeCal = CAL_DEFAULT;
            default:      decodeCal = CAL_BAD;
        endcase
    endfunction

    emr_cmd_decode uDecode (
        .csN      (cmdS2_q[3]),
        .rasN     (cmdS2_q[2]),
        .casN     (cmdS2_q[1]),
        .weN      (cmdS2_q[0]),
        .bankAddr (bankS2_q),
        .loadOne  (loadOne),
        .loadTwo  (loadTwo)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cmdS1_q  <= 4'hF;
            cmdS2_q  <= 4'hF;
            bankS1_q <= 2'h0;
            bankS2_q <= 2'h0;
            addrS1_q <= 16'h0000;
            addrS2_q <= 16'h0000;
            srS1_q   <= 1'b0;
            srS2_q   <= 1'b0;
        end else begin
            cmdS1_q  <= {csN, rasN, casN, weN};
            cmdS2_q  <= cmdS1_q;
            bankS1_q <= bankAddr;
            bankS2_q <= bankS1_q;
            addrS1_q <= addr;
            addrS2_q <= addrS1_q;
            srS1_q   <= selfRefresh;
            srS2_q   <= srS1_q;
        end
    end

    // Register contents and decoded fields.
    always_comb begin
        one_d  = one_q;
        two_d  = two_q;
        weak_d = weak_q;
        term_d = term_q;
        lat_d  = lat_q;
        cal_d  = cal_q;
        comp_d = comp_q;
        qoff_d = qoff_q;
        if (loadOne) begin
            one_d  = addrS2_q[EMR_ONE_W-1:0]; // [RULE_01] [RULE_06] [RULE_20]
            weak_d = addrS2_q[EMR_DRV_BIT]; // [RULE_08]
            term_d = {addrS2_q[EMR_TERM_HI], addrS2_q[EMR_TERM_LO]}; // [RULE_09]
            cal_d  = decodeCal(addrS2_q[EMR_CAL_LO +: 3]); // [RULE_11]
            // Adjust keeps the old latency; reserved codes are refused as well.
            if (decodeCal(addrS2_q[EMR_CAL_LO +: 3]) != CAL_ADJUST
                && addrS2_q[EMR_LAT_LO +: 3] <= EMR_LAT_MAX) begin
                lat_d = addrS2_q[EMR_LAT_LO +: 3]; // [RULE_10] [RULE_18]
            end
            comp_d = addrS2_q[EMR_STROBE_BIT]; // [RULE_13]
            qoff_d = addrS2_q[EMR_QOFF_BIT]; // [RULE_14]
        end
        if (loadTwo) begin
            two_d = addrS2_q; // [RULE_02] [RULE_20]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            one_q  <= EMR_ONE_RST;
            two_q  <= EMR_TWO_RST;
            weak_q <= 1'b0;
            term_q <= EMR_TERM_OFF;
            lat_q  <= 3'h0;
            cal_q  <= CAL_EXIT;
            comp_q <= 1'b0;
            qoff_q <= 1'b0;
        end else begin
            one_q  <= one_d;
            two_q  <= two_d;
            weak_q <= weak_d;
            term_q <= term_d;
            lat_q  <= lat_d;
            cal_q  <= cal_d;
            comp_q <= comp_d;
            qoff_q <= qoff_d;
        end
    end

    // Loop state: programmed enable gated by self refresh, with a lock counter.
    always_comb begin
        dllOn_d   = !one_d[EMR_DLL_BIT] && !srS2_q; // [RULE_07] [RULE_16]
        lockCnt_d = lockCnt_q;
        locked_d  = locked_q;
        if (!dllOn_d) begin
            lockCnt_d = 8'h00;
            locked_d  = 1'b0;
        end else if (!dllOn_q) begin
            lockCnt_d = 8'h00;
            locked_d  = 1'b0;
        end else if (!locked_q) begin
            // The status flag only informs; the read guard stays with the controller.
            lockCnt_d = lockCnt_q + 8'h01;
            locked_d  = (lockCnt_q + 8'h01) >= EMR_LOCK_CNT; // [RULE_17]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dllOn_q   <= 1'b0;
            lockCnt_q <= 8'h00;
            locked_q  <= 1'b0;
        end else begin
            dllOn_q   <= dllOn_d;
            lockCnt_q <= lockCnt_d;
            locked_q  <= locked_d;
        end
    end

    always_comb begin
        dllOn             = dllOn_q;
        weakDrive         = weak_q;
        termSel           = term_q;
        addedLatency      = lat_q;
        driverCalibration = cal_q;
        strobeCompOff     = comp_q;
        outputsOff        = qoff_q;
        dllLocked         = locked_q;
        emrOneValue       = one_q;
        emrTwoValue       = two_q;
    end

    // Enabled cycles are counted apart from the lock counter, so the lock check stays independent.
    always_comb begin
        onCycles_d = 9'h000;
        if (dllOn_q) begin
            onCycles_d = onCycles_q;
            if (onCycles_q != 9'h1FF) begin
                onCycles_d = onCycles_q + 9'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            onCycles_q <= 9'h000;
        end else begin
            onCycles_q <= onCycles_d;
        end
    end

    property p_load_one;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne |=> (one_q == $past(addrS2_q[EMR_ONE_W-1:0]));
    endproperty
    a_load_one: assert property (p_load_one) else $error("first register not loaded"); // [RULE_01]

    property p_load_two;
        @(posedge ref_clk) disable iff (!rst_b)
        loadTwo |=> (two_q == $past(addrS2_q));
    endproperty
    a_load_two: assert property (p_load_two) else $error("second register not loaded"); // [RULE_02]

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        !loadOne && !loadTwo |=> $stable(one_q) && $stable(two_q);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without command"); // [RULE_20]

    // The first edge after reset still shows the reset value of the enable, so it is skipped.
    property p_dll;
        @(posedge ref_clk) disable iff (!rst_b)
        $past(rst_b) |-> dllOn_q == (!one_q[EMR_DLL_BIT] && !$past(srS2_q));
    endproperty
    a_dll: assert property (p_dll) else $error("loop enable wrong"); // [RULE_07]

    property p_selfref;
        @(posedge ref_clk) disable iff (!rst_b)
        srS2_q |=> !dllOn_q && !dllLocked;
    endproperty
    a_selfref: assert property (p_selfref) else $error("loop on in self refresh"); // [RULE_16]

    property p_term;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne |=> termSel == {one_q[EMR_TERM_HI], one_q[EMR_TERM_LO]}
            && weakDrive == one_q[EMR_DRV_BIT];
    endproperty
    a_term: assert property (p_term) else $error("termination or drive wrong"); // [RULE_09]

    property p_lat_legal;
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |-> addedLatency <= EMR_LAT_MAX;
    endproperty
    a_lat_legal: assert property (p_lat_legal) else $error("added latency reserved"); // [RULE_10]

    property p_lat_load;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne && addrS2_q[EMR_CAL_LO +: 3] != EMR_CAL_ADJ
            && addrS2_q[EMR_LAT_LO +: 3] <= EMR_LAT_MAX
            |=> addedLatency == $past(addrS2_q[EMR_LAT_LO +: 3]);
    endproperty
    a_lat_load: assert property (p_lat_load) else $error("latency not loaded"); // [RULE_10]

    property p_cal_default;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne && addrS2_q[EMR_CAL_LO +: 3] == EMR_CAL_DEF
            |=> driverCalibration == CAL_DEFAULT;
    endproperty
    a_cal_default: assert property (p_cal_default) else $error("cal default lost"); // [RULE_11]

    property p_adjust;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne && addrS2_q[EMR_CAL_LO +: 3] == EMR_CAL_ADJ
            |=> $stable(addedLatency) && driverCalibration == CAL_ADJUST;
    endproperty
    a_adjust: assert property (p_adjust) else $error("adjust changed latency"); // [RULE_18]

    property p_strobe;
        @(posedge ref_clk) disable iff (!rst_b)
        loadOne |=> strobeCompOff == one_q[EMR_STROBE_BIT] && outputsOff == one_q[EMR_QOFF_BIT];
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe or buffer bit wrong"); // [RULE_13]

    property p_lock;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(dllOn_q) |-> !dllLocked [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("loop locked too soon"); // [RULE_17]

    property p_lock_time;
        @(posedge ref_clk) disable iff (!rst_b)
        dllLocked == (dllOn_q && onCycles_q >= EMR_LOCK_CYC);
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("loop lock time wrong"); // [RULE_17]

    c_one:  cover property (@(posedge ref_clk) disable iff (!rst_b) loadOne);
    c_two:  cover property (@(posedge ref_clk) disable iff (!rst_b) loadTwo);
    c_lock: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(dllLocked));
    c_sr:   cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(srS2_q) && dllOn_d);
    c_adj:  cover property (@(posedge ref_clk) disable iff (!rst_b)
        driverCalibration == CAL_ADJUST);
endmodule
`default_nettype wire

//--- emr_ctrl_model.sv
// Controller model that issues mode register set commands to the block.
`timescale 1ns/1ps
`default_nettype none
module emr_ctrl_model
    import emr_pkg::*;
(
    // Clock.
    input  wire logic        ref_clk,
    // Command and address pins.
    output var  logic        csN,
    output var  logic        rasN,
    output var  logic        casN,
    output var  logic        weN,
    output var  logic [1:0]  bankAddr,
    output var  logic [15:0] addr
);
    initial begin
        {csN, rasN, casN, weN} = 4'hf;
        bankAddr = 2'h0;
        addr = 16'h0000;
    end
    // Only mode set commands are ever sent, so all banks stay precharged.
    task automatic issue(input logic [1:0] bank, input logic [15:0] a);
        @(posedge ref_clk);
        {csN, rasN, casN, weN} <= 4'h0;
        bankAddr <= bank;
        addr <= a;
    endtask
    // Released lines flip so a stale command value is never mistaken for a held one.
    task automatic idle(input int n);
        @(posedge ref_clk);
        {csN, rasN, casN, weN} <= 4'hf;
        bankAddr <= ~bankAddr;
        addr <= ~addr;
        repeat (n - 1) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the extended mode register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import emr_pkg::*;
    typedef struct packed {logic [12:0] one; logic [15:0] two; logic [2:0] lat;} emr_note_t;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic selfRefresh = 1'b0;
    wire logic csN, rasN, casN, weN, dllOn, weakDrive, strobeCompOff, outputsOff, dllLocked;
    wire logic [1:0] bankAddr, termSel;
    wire logic [15:0] addr, emrTwoValue;
    wire logic [2:0] addedLatency;
    wire logic [12:0] emrOneValue;
    wire emr_cal_t driverCalibration;
    int bad_count = 0;
    int tests_run = 0;
    int seed = 62;
    emr_note_t notes[$];
    emr_note_t n;
    logic [12:0] expOne = 13'h0000;
    logic [15:0] expTwo = 16'h0000;
    logic [2:0] expLat = 3'h0;
    logic [2:0] pipe = 3'h0;
    logic [2:0] calTab [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    emr_cal_t calEnum [8] = '{CAL_EXIT, CAL_HIGH, CAL_LOW, CAL_BAD, CAL_ADJUST, CAL_BAD,
                              CAL_BAD, CAL_DEFAULT};

    emr_ctrl_model emr_ctrl_model_i (.ref_clk(ref_clk), .csN(csN), .rasN(rasN), .casN(casN),
        .weN(weN), .bankAddr(bankAddr), .addr(addr));
    emr_extended_mode emr_extended_mode_i (.ref_clk(ref_clk), .rst_b(rst_b), .csN(csN),
        .rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .addr(addr),
        .selfRefresh(selfRefresh), .dllOn(dllOn), .weakDrive(weakDrive), .termSel(termSel),
        .addedLatency(addedLatency), .driverCalibration(driverCalibration),
        .strobeCompOff(strobeCompOff), .outputsOff(outputsOff), .dllLocked(dllLocked),
        .emrOneValue(emrOneValue), .emrTwoValue(emrTwoValue));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        #20000;
        bad_count++;
        final_report();
    end

    // Every command lands two edges after it is sampled, so compare one note then.
    always @(posedge ref_clk) begin
        pipe <= {pipe[1:0], rst_b && {csN, rasN, casN, weN} == 4'h0};
        if (pipe[1]) begin
            #1;
            n = notes.pop_front();
            chk(emrOneValue, n.one);
            chk(emrTwoValue, n.two);
            chk(addedLatency, n.lat);
            chk(dllOn, !n.one[0]);
            chk(weakDrive, n.one[1]);
            chk(termSel, {n.one[6], n.one[2]});
            chk(driverCalibration, calEnum[n.one[9:7]]);
            chk(strobeCompOff, n.one[10]);
            chk(outputsOff, n.one[12]);
        end
    end

    initial begin : main
        logic [15:0] a;
        logic [1:0] bank;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        // Banks cycle through all four selections, so both registers get programmed.
        for (int i = 0; i < 40; i++) begin
            bank = 2'((i / 5) % 4);
            a = 16'($random(seed));
            a[11] = 1'b0;
            {a[6], a[2]} = 2'(i % 4);
            a[5:3] = 3'(i % 8);
            a[9:7] = calTab[i % 5];
            if (bank == EMR_SEL_ONE) begin
                if (a[5:3] <= EMR_LAT_MAX && a[9:7] != EMR_CAL_ADJ) expLat = a[5:3];
                expOne = a[12:0];
            end else if (bank == EMR_SEL_TWO) begin
                expTwo = a;
            end
            notes.push_back('{expOne, expTwo, expLat});
            emr_ctrl_model_i.issue(bank, a);
            if (i % 3 != 0) emr_ctrl_model_i.idle(1 + $unsigned($random(seed)) % 3);
        end
        expOne = 13'h0000;
        expLat = 3'h0;
        notes.push_back('{expOne, expTwo, expLat});
        emr_ctrl_model_i.issue(EMR_SEL_ONE, 16'h0000);
        emr_ctrl_model_i.idle(4);
        selfRefresh <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(dllOn, 1'b0);
        chk(dllLocked, 1'b0);
        @(posedge ref_clk);
        selfRefresh <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(dllOn, 1'b1);
        repeat (198) @(posedge ref_clk);
        #1;
        chk(dllLocked, 1'b0);
        @(posedge ref_clk);
        #1;
        chk(dllLocked, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
